// [design/csef_pkg.sv]
// constants shared by the charger status and event flag block
// assumes a 20 MHz system clock and an 8-bit register port
package csef_pkg;

    // clock rate
    localparam int CLK_MHZ = 20;

    // contact detect timeout, in microseconds (plain default, set per product)
    localparam int DCD_TIMEOUT_US = 1000;
    localparam int DCD_TIMEOUT_CYCLES = DCD_TIMEOUT_US * CLK_MHZ;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_CHG_FIELDS = 8'h02;
    localparam logic [7:0] ADDR_INPUT_STATUS = 8'h03;
    localparam logic [7:0] ADDR_CONDITION = 8'h04;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h05;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;

    // condition status bit positions
    localparam int ST_SHUTDOWN = 3;
    localparam int ST_TREG = 2;
    localparam int ST_DCD_TO = 1;
    localparam int ST_TIMEOUT = 0;

    // event flag bit positions
    localparam int EV_TYPE = 7;
    localparam int EV_OVP = 6;
    localparam int EV_SYSBAT = 5;
    localparam int EV_RESERVED = 4;
    localparam int EV_BATTERY_DETECT_STATE = 3;
    localparam int EV_STATE = 2;
    localparam int EV_TREG = 1;
    localparam int EV_TIMEOUT = 0;

    // input status register bit positions (0x03 mirror)
    localparam int IN_OVP = 2;
    localparam int IN_SYSBAT = 1;
    localparam int IN_BATTERY_DETECT_STATE = 0;

    // charger state code shown while timed out
    localparam logic [2:0] STATE_TIMEOUT = 3'h7;

    // control register: bit 0 enables the contact detect timer
    localparam int CTL_DCD_EN = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h01;

    // synchroniser vector layout
    localparam int SY_W = 16;
    localparam int SY_TYPE_LO = 0;
    localparam int SY_STATE_LO = 4;
    localparam int SY_OVP = 7;
    localparam int SY_SYSBAT = 8;
    localparam int SY_BATTERY_DETECT_STATE = 9;
    localparam int SY_BATDONE = 10;
    localparam int SY_STVALID = 11;
    localparam int SY_SHUTDOWN = 12;
    localparam int SY_TREG = 13;
    localparam int SY_TIMEOUT = 14;
    localparam int SY_DCD_RUN = 15;

    // cycles after reset before change detection is trusted
    localparam logic [1:0] ARM_CYCLES = 2'h3;

endpackage

// [design/csef_status_flags.sv]
// charger condition status register and clear-on-read event flag register
// assumes status sources arrive asynchronously and are synchronised here;
// software uses a single-cycle read/write strobe port, read data one cycle later
//
// Summary of operation
// R1 - status 0x04 bit 3 reads one while in thermal shutdown.
// R2 - status bit 2 reads one while charge current is lowered for heat.
// R3 - status bit 1 becomes one once the contact detect wait runs its full timeout.
// R4 - contact detect timeout bit reads zero while timer not expired or not running.
// R5 - status bit 0 shows charger timeout; state field in 0x02 then reads 111.
// R6 - status and flags read-only; reading flags clears returned flags; reserved read zero.
// R7 - flag bit 7 sets on any change of the charger type field.
// R8 - flag bit 6 sets on any change of input overvoltage status.
// R9 - flag bit 5 sets on any change of system-to-battery voltage status.
// R10 - flag bit 3 sets on battery detect change or first detection after reset.
// R11 - flag bit 2 sets on any change of the charger state field.
// R12 - flag bit 2 also sets when the first charger state is entered.
// R13 - flag bit 1 sets on any change of thermal current reduction status.
// R14 - flag bit 0 sets on any change of charger timeout status.
`timescale 1ns/10ps

module csef_status_flags #(
    parameter int DCD_CYCLES = csef_pkg::DCD_TIMEOUT_CYCLES,
    parameter int CNT_W = 32
) (
    input wire logic mclk_i, // 20 MHz system clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic [csef_pkg::ADDR_W-1:0] addr_i, // register address
    input wire logic [csef_pkg::DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [csef_pkg::DATA_W-1:0] rdata_o, // read data, cycle after rd_i
    input wire logic [3:0] charger_type_field_i, // detected charger type
    input wire logic [2:0] charger_state_field_i, // charger state code
    input wire logic charger_state_valid_i, // charger has entered a state
    input wire logic input_overvoltage_state_i, // input overvoltage
    input wire logic sys_batt_voltage_state_i, // system-to-battery voltage state
    input wire logic battery_detect_state_i, // battery detection result
    input wire logic battery_detect_done_i, // a battery detection has completed
    input wire logic thermal_shutdown_state_i, // device in thermal shutdown
    input wire logic thermal_current_reduction_i, // charge current lowered for heat
    input wire logic charge_timeout_state_i, // charger reached timeout
    input wire logic contact_detect_running_i // contact detect wait in progress
);
    import csef_pkg::*;

    localparam logic [CNT_W-1:0] DCD_LAST = CNT_W'(DCD_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers: every status source is asynchronous to mclk_i

    logic [SY_W-1:0] raw_w;
    logic [SY_W-1:0] sy1_q, sy1_d;
    logic [SY_W-1:0] sy2_q, sy2_d;

    assign raw_w = {contact_detect_running_i, charge_timeout_state_i,
                    thermal_current_reduction_i, thermal_shutdown_state_i,
                    charger_state_valid_i, battery_detect_done_i,
                    battery_detect_state_i, sys_batt_voltage_state_i,
                    input_overvoltage_state_i, charger_state_field_i,
                    charger_type_field_i};

    // a field caught mid-change may flag one extra change; flags only ever over-report
    always_comb begin
        sy1_d = raw_w;
        sy2_d = sy1_q;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= sy1_d;
            sy2_q <= sy2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // contact detect timer

    logic [CNT_W-1:0] dcd_cnt_q, dcd_cnt_d;
    logic dcd_to_q, dcd_to_d;
    logic [DATA_W-1:0] ctl_q, ctl_d;
    logic dcd_active_w;

    assign dcd_active_w = sy2_q[SY_DCD_RUN] & ctl_q[CTL_DCD_EN];

    always_comb begin
        dcd_cnt_d = '0;
        dcd_to_d = 1'b0;
        // leaving the wait or disabling the timer drops the bit at once
        if (dcd_active_w) begin
            dcd_to_d = dcd_to_q | (dcd_cnt_q == DCD_LAST); // R3 R4
            // counter parks at the end so a very long wait cannot wrap
            dcd_cnt_d = (dcd_cnt_q == DCD_LAST) ? dcd_cnt_q : dcd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dcd_cnt_q <= '0;
            dcd_to_q <= 1'b0;
        end else begin
            dcd_cnt_q <= dcd_cnt_d;
            dcd_to_q <= dcd_to_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status views

    logic [3:0] cond_w;
    logic [2:0] state_view_w;

    always_comb begin
        cond_w = '0;
        cond_w[ST_SHUTDOWN] = sy2_q[SY_SHUTDOWN]; // R1
        cond_w[ST_TREG] = sy2_q[SY_TREG]; // R2
        cond_w[ST_DCD_TO] = dcd_to_q; // R3 R4
        cond_w[ST_TIMEOUT] = sy2_q[SY_TIMEOUT]; // R5
        state_view_w = sy2_q[SY_STATE_LO +: 3];
        if (sy2_q[SY_TIMEOUT]) begin
            state_view_w = STATE_TIMEOUT; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change detection and event flags

    logic [SY_W-1:0] prev_q, prev_d;
    logic [1:0] arm_q, arm_d;
    logic [2:0] prev_view_w;
    logic bat_seen_q, bat_seen_d;
    logic st_seen_q, st_seen_d;
    logic [DATA_W-1:0] flags_q, flags_d;
    logic [DATA_W-1:0] set_w;
    logic armed_w;
    logic rd_flags_w;

    assign armed_w = (arm_q == ARM_CYCLES);
    assign rd_flags_w = rd_i & (addr_i == ADDR_EVENT_FLAGS);

    // the state flag follows the field as software reads it, timeout code included
    always_comb begin
        prev_view_w = prev_q[SY_STATE_LO +: 3];
        if (prev_q[SY_TIMEOUT]) begin
            prev_view_w = STATE_TIMEOUT; // R11
        end
    end

    always_comb begin
        set_w = '0;
        // sync flops and prev_q leave reset at zero; arming hides that false step
        if (armed_w) begin
            set_w[EV_TYPE] = sy2_q[SY_TYPE_LO +: 4] != prev_q[SY_TYPE_LO +: 4]; // R7
            set_w[EV_OVP] = sy2_q[SY_OVP] != prev_q[SY_OVP]; // R8
            set_w[EV_SYSBAT] = sy2_q[SY_SYSBAT] != prev_q[SY_SYSBAT]; // R9
            set_w[EV_BATTERY_DETECT_STATE] = sy2_q[SY_BATTERY_DETECT_STATE] != prev_q[SY_BATTERY_DETECT_STATE]; // R10
            set_w[EV_STATE] = state_view_w != prev_view_w; // R11
            set_w[EV_TREG] = sy2_q[SY_TREG] != prev_q[SY_TREG]; // R13
            set_w[EV_TIMEOUT] = sy2_q[SY_TIMEOUT] != prev_q[SY_TIMEOUT]; // R14
        end
        // first completion after reset is caught even before arming
        if (sy2_q[SY_BATDONE] & ~bat_seen_q) begin
            set_w[EV_BATTERY_DETECT_STATE] = 1'b1; // R10
        end
        if (sy2_q[SY_STVALID] & ~st_seen_q) begin
            set_w[EV_STATE] = 1'b1; // R12
        end
        set_w[EV_RESERVED] = 1'b0; // R6
    end

    always_comb begin
        prev_d = sy2_q;
        arm_d = armed_w ? arm_q : arm_q + 2'h1;
        bat_seen_d = bat_seen_q | sy2_q[SY_BATDONE];
        st_seen_d = st_seen_q | sy2_q[SY_STVALID];
        // a new event in the reading cycle survives the clear
        flags_d = (rd_flags_w ? '0 : flags_q) | set_w; // R6
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
            arm_q <= '0;
            bat_seen_q <= 1'b0;
            st_seen_q <= 1'b0;
            flags_q <= '0;
        end else begin
            prev_q <= prev_d;
            arm_q <= arm_d;
            bat_seen_q <= bat_seen_d;
            st_seen_q <= st_seen_d;
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port: writes only reach the control register

    logic [DATA_W-1:0] rdata_q, rdata_d;

    always_comb begin
        ctl_d = ctl_q;
        if (wr_i && addr_i == ADDR_CONTROL) begin
            ctl_d = {7'h00, wdata_i[CTL_DCD_EN]};
        end
        // data stands for exactly one cycle after the read strobe
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_CHG_FIELDS: rdata_d = {sy2_q[SY_TYPE_LO +: 4], 1'b0, state_view_w}; // R5
                ADDR_INPUT_STATUS: rdata_d = {5'h00, sy2_q[SY_OVP], sy2_q[SY_SYSBAT],
                                              sy2_q[SY_BATTERY_DETECT_STATE]};
                ADDR_CONDITION: rdata_d = {4'h0, cond_w}; // R1 R6
                ADDR_EVENT_FLAGS: rdata_d = flags_q; // R6
                ADDR_CONTROL: rdata_d = ctl_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctl_q <= CONTROL_RESET;
            rdata_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence rd_cond_s;
        rd_i && addr_i == ADDR_CONDITION;
    endsequence

    sequence rd_flags_s;
        rd_i && addr_i == ADDR_EVENT_FLAGS;
    endsequence

    sequence quiet_flags_s;
        rd_flags_s ##0 (set_w == '0);
    endsequence

    sequence read_event_s;
        rd_flags_s ##0 (set_w != '0);
    endsequence

    cond_read_a: assert property (rd_cond_s |=> rdata_o == {4'h0, $past(cond_w)}) // R1
        else $error("condition status read data wrong");

    shutdown_map_a: assert property ( // R1
        rd_cond_s ##0 sy2_q[SY_SHUTDOWN] |=> rdata_o[ST_SHUTDOWN]
    )
        else $error("thermal shutdown not reported in bit 3");

    shutdown_clear_a: assert property ( // R1
        rd_cond_s ##0 !sy2_q[SY_SHUTDOWN] |=> !rdata_o[ST_SHUTDOWN]
    )
        else $error("thermal shutdown bit set without cause");

    treg_map_a: assert property (rd_cond_s ##0 !sy2_q[SY_TREG] |=> !rdata_o[ST_TREG]) // R2
        else $error("thermal reduction bit set without cause");

    treg_set_a: assert property (rd_cond_s ##0 sy2_q[SY_TREG] |=> rdata_o[ST_TREG]) // R2
        else $error("thermal reduction not reported in bit 2");

    dcd_full_a: assert property ($rose(dcd_to_q) |-> $past(dcd_cnt_q) == DCD_LAST) // R3
        else $error("contact detect timeout before full duration");

    dcd_idle_a: assert property (!dcd_active_w |=> !dcd_to_q) // R4
        else $error("contact detect timeout bit set while timer idle");

    dcd_early_a: assert property (dcd_cnt_q != DCD_LAST && !dcd_to_q |=> !dcd_to_q) // R3
        else $error("contact detect timeout set before the last count");

    timeout_state_a: assert property ( // R5
        rd_i && addr_i == ADDR_CHG_FIELDS && sy2_q[SY_TIMEOUT] |=> rdata_o[2:0] == STATE_TIMEOUT
    )
        else $error("charger state not 111 during timeout");

    tmo_map_a: assert property (rd_cond_s ##0 sy2_q[SY_TIMEOUT] |=> rdata_o[ST_TIMEOUT]) // R5
        else $error("charger timeout not reported in bit 0");

    flag_clear_a: assert property (quiet_flags_s |=> flags_q == '0) // R6
        else $error("event flags not cleared by read");

    flag_return_a: assert property (rd_flags_s |=> rdata_o == $past(flags_q)) // R6
        else $error("event flag read data wrong");

    reserved_zero_a: assert property (flags_q[EV_RESERVED] == 1'b0) // R6
        else $error("reserved event flag bit set");

    set_wins_a: assert property (read_event_s |=> flags_q == $past(set_w)) // R6
        else $error("event in the reading cycle lost");

    flags_hold_a: assert property ( // R6
        !rd_flags_w |=> (flags_q & $past(flags_q)) == $past(flags_q)
    )
        else $error("event flag lost without a read");

    rdata_idle_a: assert property (!rd_i |=> rdata_o == '0) // R6
        else $error("read data present without a read");

    type_change_a: assert property ( // R7
        armed_w && $changed(sy2_q[SY_TYPE_LO +: 4]) |=> flags_q[EV_TYPE]
    )
        else $error("charger type change lost");

    ovp_change_a: assert property ( // R8
        armed_w && sy2_q[SY_OVP] != prev_q[SY_OVP] |=> flags_q[EV_OVP]
    )
        else $error("overvoltage change lost");

    sysbat_change_a: assert property ( // R9
        armed_w && sy2_q[SY_SYSBAT] != prev_q[SY_SYSBAT] |=> flags_q[EV_SYSBAT]
    )
        else $error("system-battery change lost");

    bat_first_a: assert property (sy2_q[SY_BATDONE] && !bat_seen_q |=> flags_q[EV_BATTERY_DETECT_STATE]) // R10
        else $error("first battery detection not flagged");

    state_change_a: assert property ( // R11
        armed_w && state_view_w != prev_view_w |=> flags_q[EV_STATE]
    )
        else $error("charger state change lost");

    state_first_a: assert property (sy2_q[SY_STVALID] && !st_seen_q |=> flags_q[EV_STATE]) // R12
        else $error("first charger state not flagged");

    treg_change_a: assert property ( // R13
        armed_w && sy2_q[SY_TREG] != prev_q[SY_TREG] |=> flags_q[EV_TREG]
    )
        else $error("thermal reduction change lost");

    tmo_change_a: assert property ( // R14
        armed_w && sy2_q[SY_TIMEOUT] != prev_q[SY_TIMEOUT] |=> flags_q[EV_TIMEOUT]
    )
        else $error("charger timeout change lost");

    ctl_write_a: assert property (
        wr_i && addr_i == ADDR_CONTROL |=> ctl_q[CTL_DCD_EN] == $past(wdata_i[CTL_DCD_EN])
    )
        else $error("control write lost");

endmodule

// [testbench/tb_charger_status_event_flags.sv]
// self-checking bench for the charger condition status and event flag block
// assumes the design's 2-flop input sync, 3-cycle arming and one-cycle read port
`timescale 1ns/10ps

`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("Error at %0t ns: got %h expected %h", $time, got, exp); \
    end \
end

module tb_charger_status_event_flags;
    import csef_pkg::*;

    // short contact detect timeout keeps the run brief
    localparam int DCD = 8;

    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [3:0] ctype = 4'h2;
    logic [2:0] cstate = 3'h1;
    logic cvalid = 1'b0;
    logic ovp = 1'b0;
    logic sysbat = 1'b0;
    logic battery_detect_state = 1'b0;
    logic batdone = 1'b0;
    logic sd = 1'b0;
    logic treg = 1'b0;
    logic tmo = 1'b0;
    logic dcdrun = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] flip_flag [7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01, 8'h04};

    always #25 mclk_i = ~mclk_i;

    csef_status_flags #(.DCD_CYCLES(DCD)) DUT (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .charger_type_field_i(ctype),
        .charger_state_field_i(cstate),
        .charger_state_valid_i(cvalid),
        .input_overvoltage_state_i(ovp),
        .sys_batt_voltage_state_i(sysbat),
        .battery_detect_state_i(battery_detect_state),
        .battery_detect_done_i(batdone),
        .thermal_shutdown_state_i(sd),
        .thermal_current_reduction_i(treg),
        .charge_timeout_state_i(tmo),
        .contact_detect_running_i(dcdrun)
    );

    ////////////////////////////////////////////////////////////////////////////

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // read data is looked at only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, exp)
    endtask

    task automatic flip(input int k);
        @(posedge mclk_i);
        case (k)
            0: ctype <= ctype ^ 4'h5;
            1: ovp <= ~ovp;
            2: sysbat <= ~sysbat;
            3: battery_detect_state <= ~battery_detect_state;
            4: treg <= ~treg;
            5: tmo <= ~tmo;
            default: cstate <= 3'h2;
        endcase
    endtask

    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        #250000;
        bad_count++;
        end_sim;
    end

    initial begin
        step(3);
        rst_n_i <= 1'b1;
        step(6);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        rd_chk(ADDR_CONDITION, 8'h00);
        rd_chk(ADDR_CONTROL, CONTROL_RESET);
        // first charger state and first battery detection after reset
        @(posedge mclk_i);
        cvalid <= 1'b1;
        batdone <= 1'b1;
        step(4);
        rd_chk(ADDR_EVENT_FLAGS, 8'h0c);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        // shutdown, reduction and timeout together
        @(posedge mclk_i);
        sd <= 1'b1;
        treg <= 1'b1;
        tmo <= 1'b1;
        cstate <= 3'h7;
        step(4);
        rd_chk(ADDR_CONDITION, 8'h0d);
        rd_chk(ADDR_CHG_FIELDS, 8'h27);
        rd_chk(ADDR_EVENT_FLAGS, 8'h07);
        // each source alone sets only its own flag; state change comes last
        for (int k = 0; k < 7; k++) begin
            flip(k);
            step(4);
            rd_chk(ADDR_EVENT_FLAGS, flip_flag[k]);
        end
        rd_chk(ADDR_CONDITION, 8'h08);
        rd_chk(ADDR_CHG_FIELDS, 8'h72);
        rd_chk(ADDR_INPUT_STATUS, 8'h07);
        // two events before one read accumulate, then both clear
        flip(1);
        flip(2);
        step(4);
        rd_chk(ADDR_EVENT_FLAGS, 8'h60);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        // an event landing in the reading cycle survives the clear
        flip(1);
        step(1);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        rd_chk(ADDR_EVENT_FLAGS, 8'h40);
        // writes to the read-only registers change nothing
        flip(1);
        step(4);
        wr_reg(ADDR_EVENT_FLAGS, 8'h00);
        wr_reg(ADDR_CONDITION, 8'hff);
        rd_chk(ADDR_EVENT_FLAGS, 8'h40);
        rd_chk(ADDR_CONDITION, 8'h08);
        rd_chk(8'h7f, 8'h00);
        // contact detect wait: early, expired, then stopped
        @(posedge mclk_i);
        dcdrun <= 1'b1;
        step(3);
        rd_chk(ADDR_CONDITION, 8'h08);
        step(16);
        rd_chk(ADDR_CONDITION, 8'h0a);
        @(posedge mclk_i);
        dcdrun <= 1'b0;
        step(4);
        rd_chk(ADDR_CONDITION, 8'h08);
        // timer disabled never expires
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h00);
        @(posedge mclk_i);
        dcdrun <= 1'b1;
        step(20);
        rd_chk(ADDR_CONDITION, 8'h08);
        wr_reg(ADDR_CONTROL, 8'h01);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        // mid-run reset: first-state and first-detection events come again
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        dcdrun <= 1'b0;
        step(3);
        rst_n_i <= 1'b1;
        step(6);
        rd_chk(ADDR_EVENT_FLAGS, 8'h0c);
        rd_chk(ADDR_CONTROL, CONTROL_RESET);
        rd_chk(ADDR_CONDITION, 8'h08);
        end_sim;
    end
endmodule
